// ===== logic/sideband_pkg.sv
// Shared constants and types for the processor sideband control block
package sideband_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;   // Strobe control register
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04; // Sticky events, write one to clear
   localparam logic [ADDR_W-1:0] OFS_MASK = 5'h08;   // Interrupt mask
   localparam logic [ADDR_W-1:0] OFS_STATE = 5'h0C;  // Live state, read only
   // ----------------------------------------------------------------
   // Field layouts and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_W = 2;
   localparam int CTRL_EN_BIT = 0;                   // Breakpoint strobes in use
   localparam int CTRL_POL_BIT = 1;                  // Strobe polarity bit
   localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
   localparam int IRQ_W = 4;
   localparam int IRQ_BP = 0;                        // Strobe pulse issued
   localparam int IRQ_HOT = 1;                       // Over-temperature rose
   localparam int IRQ_WARM = 2;                      // Warm flag rose
   localparam int IRQ_RSTI = 3;                      // Reset interrupt released
   localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
   localparam int ST_HOT = 0;
   localparam int ST_WARM = 1;
   localparam int ST_SHUT = 2;
   localparam int ST_PEND = 3;
   localparam int ST_BYP = 4;
   localparam int ST_ARM = 5;
   localparam int ST_ROUTE = 6;
   localparam int ST_RATIO = 8;
   localparam int RATIO_W = 5;
   localparam logic [RATIO_W-1:0] RATIO_RST = 5'h00;
   // ----------------------------------------------------------------
   // Clock tree source select codes and speed test
   // ----------------------------------------------------------------
   localparam logic [1:0] SEL_SPEED_ARM = 2'h0;
   localparam logic [1:0] SEL_SCAN = 2'h1;
   localparam logic [1:0] SEL_CORE = 2'h2;
   localparam logic [1:0] SEL_TCK = 2'h3;
   localparam logic [1:0] SPD_BURST = 2'h2;          // Core clock cycles per trigger
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {ROUTE_CORE, ROUTE_TCK, ROUTE_SCAN} clk_route_t;
   typedef enum logic [1:0] {BRK_IDLE, BRK_WAIT, BRK_PULSE} brk_state_t;
endpackage

// ===== logic/sync2.sv
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1; // First stage, read only by s2
      logic [W-1:0] s2; // Safe stage
   } sync_t;
   sync_t s_r, s_nxt;

   // Shift the levels along
   always_comb begin
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
   end

   // State register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.s2;
endmodule

// ===== logic/bus_clock_gen.sv
// Bus clock tick and half-rate heartbeat generator
`timescale 1ns/1ps
module bus_clock_gen
   import sideband_pkg::*;
#(
   parameter int RW = RATIO_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Ratio, processor cycles per bus clock minus one
   input wire logic [RW-1:0] ratio,
   // Outputs
   output logic bus_tick,
   output logic heartbeat
);
   typedef struct packed {
      logic [RW-1:0] cnt; // Processor cycles into bus clock
      logic hb;           // Heartbeat level
   } gen_t;
   gen_t s_r, s_nxt;

   // Last processor cycle of each bus clock
   assign bus_tick = (s_r.cnt >= ratio);

   // Count processor cycles, flip heartbeat once per bus clock
   always_comb begin
      s_nxt = s_r;
      s_nxt.cnt = bus_tick ? '0 : RW'(s_r.cnt + 1'b1);
      s_nxt.hb = s_r.hb ^ bus_tick;
   end

   // State register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign heartbeat = s_r.hb;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   AST_HB_TOGGLE: assert property (bus_tick |=> heartbeat != $past(heartbeat))
      else $error("heartbeat missed a bus clock flip");
   AST_HB_HOLD: assert property (!bus_tick && $stable(ratio) |=> $stable(heartbeat))
      else $error("heartbeat moved inside a bus clock");
endmodule

// ===== logic/sideband_ctrl.sv
// Processor sideband control: strobe, clock config, scan and thermal
// What this block does
// - Breakpoint hit gives one bus clock pulse quickly
// - Pulse level follows strobe polarity bit
// - Loop bypass routes system clock to core
// - Two-bit select picks the clock tree source
// - Select codes: 10 core, 11 test, 00 armed, 01 scan
// - Heartbeat is half bus clock, even duty
// - Shift mode enables scan, blocks RAM writes
// - Chain select joins scan into one chain
// - Hot flags and shuts down unless overridden
// - Warm flag tracks near-top temperature
// - Reset interrupts wait for die above minimum unless bypassed
`timescale 1ns/1ps
module sideband_ctrl
   import sideband_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // AXI4-Lite slave
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic irq,
   // Breakpoint
   input wire logic bp_trigger,
   output logic bp_strobe,
   // Clock configuration
   input wire logic hard_reset_in,
   input wire logic [RATIO_W-1:0] ratio_cfg_in,
   input wire logic loop_bypass_in,
   input wire logic [1:0] clock_tree_source_select,
   output logic [RATIO_W-1:0] ratio_cfg,
   output logic proc_clk_bypass,
   output logic pll_enable,
   output clk_route_t clk_route,
   output logic speed_trig_armed,
   output logic heartbeat_out,
   // Scan
   input wire logic shift_mode_en,
   input wire logic single_chain_select,
   output logic scan_mode,
   output logic ram_we_block,
   output logic scan_single_chain,
   // Thermal
   input wire logic hot_raw,
   input wire logic warm_raw,
   input wire logic above_min_raw,
   input wire logic overtemp_override,
   input wire logic cold_start_wait_bypass,
   input wire logic reset_irq_req,
   output logic overtemp_flag,
   output logic warm_flag,
   output logic shutdown,
   output logic reset_irq_take
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;   // Strobe control register
      logic [IRQ_W-1:0] status;  // Sticky events
      logic [IRQ_W-1:0] mask;    // Interrupt mask
      logic irq;                 // Interrupt level
      brk_state_t brk;           // Strobe sequencer
      logic pin;                 // Strobe pin level
      logic again;               // Trigger queued during a pulse
      logic [RATIO_W-1:0] ratio; // Latched ratio
      logic byp;                 // Latched loop bypass
      logic sel1_prev;           // Select bit 1 last cycle
      logic armed;               // Speed test trigger armed
      logic [1:0] burst;         // Speed test core cycles left
      clk_route_t route;         // Clock tree source
      logic scan;                // Scan mode
      logic wblk;                // RAM write block
      logic single;              // Single chain
      logic hot;                 // Over-temperature flag
      logic warm;                // Warm flag
      logic shut;                // Shutdown request
      logic pend;                // Reset interrupt pending
      logic take;                // Reset interrupt released
      logic bvalid;              // Write answer pending
      logic [1:0] bresp;         // Write answer code
      logic rvalid;              // Read answer pending
      logic [31:0] rdata;        // Read data
      logic [1:0] rresp;         // Read answer code
   } st_t;
   st_t s_r, s_nxt;

   logic bus_tick;          // Last processor cycle of a bus clock
   logic [2:0] temp_s;      // Synchronised hot, warm, above minimum
   logic wen;               // Write taken this cycle
   logic ren;               // Read taken this cycle
   logic spd_edge;          // Speed test trigger edge
   logic [IRQ_W-1:0] ev;    // Events this cycle
   logic [IRQ_W-1:0] clr;   // Clears this cycle

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Byte-lane merge of a write into a register word
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Clock tree source for a select code
   function automatic clk_route_t sel_route(input logic [1:0] sel);
      clk_route_t r;
      r = ROUTE_TCK;
      unique case (sel)
         SEL_CORE: r = ROUTE_CORE;
         SEL_TCK: r = ROUTE_TCK;
         SEL_SPEED_ARM: r = ROUTE_TCK;
         SEL_SCAN: r = ROUTE_SCAN;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   // Comparator levels are asynchronous to mclk
   sync2 #(.W(3)) u_temp_sync (
      .mclk(mclk),
      .rstn(rstn),
      .d({above_min_raw, warm_raw, hot_raw}),
      .q(temp_s)
   );

   // Bus clock from latched ratio, heartbeat at half its rate
   bus_clock_gen #(.RW(RATIO_W)) u_bus_clk (
      .mclk(mclk),
      .rstn(rstn),
      .ratio(s_r.ratio),
      .bus_tick(bus_tick),
      .heartbeat(heartbeat_out)
   );

   // ----------------------------------------------------------------
   // Handshakes
   // ----------------------------------------------------------------
   assign wen = awvalid && wvalid && !s_r.bvalid;
   assign ren = arvalid && !s_r.rvalid;
   assign awready = wen;
   assign wready = wen;
   assign arready = ren;
   assign spd_edge = s_r.armed && !s_r.sel1_prev && clock_tree_source_select[1];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      clr = '0;
      ev = '0;
      // Register writes
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (wen) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         unique case (awaddr)
            OFS_CTRL: s_nxt.ctrl = CTRL_W'(wmerge(32'(s_r.ctrl), wdata, wstrb));
            OFS_STATUS: clr = wstrb[0] ? wdata[IRQ_W-1:0] : '0;
            OFS_MASK: s_nxt.mask = IRQ_W'(wmerge(32'(s_r.mask), wdata, wstrb));
            OFS_STATE: ;    // Read only, write ignored
            default: s_nxt.bresp = RESP_SLVERR;
         endcase
      end
      // Register reads
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (ren) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = RESP_OKAY;
         s_nxt.rdata = '0;
         unique case (araddr)
            OFS_CTRL: s_nxt.rdata[CTRL_W-1:0] = s_r.ctrl;
            OFS_STATUS: s_nxt.rdata[IRQ_W-1:0] = s_r.status;
            OFS_MASK: s_nxt.rdata[IRQ_W-1:0] = s_r.mask;
            OFS_STATE: begin
               s_nxt.rdata[ST_HOT] = s_r.hot;
               s_nxt.rdata[ST_WARM] = s_r.warm;
               s_nxt.rdata[ST_SHUT] = s_r.shut;
               s_nxt.rdata[ST_PEND] = s_r.pend;
               s_nxt.rdata[ST_BYP] = s_r.byp;
               s_nxt.rdata[ST_ARM] = s_r.armed;
               s_nxt.rdata[ST_ROUTE +: 2] = s_r.route;
               s_nxt.rdata[ST_RATIO +: RATIO_W] = s_r.ratio;
            end
            default: s_nxt.rresp = RESP_SLVERR;
         endcase
      end
      // Breakpoint strobe sequencer, pulse spans tick to tick
      unique case (s_r.brk)
         BRK_IDLE: begin
            if (bp_trigger && s_r.ctrl[CTRL_EN_BIT]) begin
               s_nxt.brk = BRK_WAIT;
            end
         end
         BRK_WAIT: begin
            if (bus_tick) begin
               s_nxt.brk = BRK_PULSE;
               s_nxt.again = 1'b0;
               ev[IRQ_BP] = 1'b1;
            end
         end
         BRK_PULSE: begin
            if (bus_tick) begin
               s_nxt.brk = (bp_trigger || s_r.again) ? BRK_WAIT : BRK_IDLE;
            end else if (bp_trigger) begin
               s_nxt.again = 1'b1; // Trigger inside the pulse earns another one
            end
         end
         default: s_nxt.brk = BRK_IDLE;
      endcase
      // Pin shows polarity bit during the pulse, its inverse otherwise
      s_nxt.pin = (s_nxt.brk == BRK_PULSE) ? s_nxt.ctrl[CTRL_POL_BIT]
                                           : !s_nxt.ctrl[CTRL_POL_BIT];
      // Configuration follows the inputs only during hard reset
      if (hard_reset_in) begin
         s_nxt.ratio = ratio_cfg_in;
         s_nxt.byp = loop_bypass_in;
      end
      // Clock tree source and speed test trigger
      s_nxt.sel1_prev = clock_tree_source_select[1];
      s_nxt.armed = (clock_tree_source_select == SEL_SPEED_ARM);
      if (spd_edge) begin
         s_nxt.burst = SPD_BURST;
      end else if (s_r.burst != 2'h0) begin
         s_nxt.burst = s_r.burst - 2'h1;
      end
      s_nxt.route = (s_nxt.burst != 2'h0) ? ROUTE_CORE
                                          : sel_route(clock_tree_source_select);
      // Scan controls
      s_nxt.scan = shift_mode_en;
      s_nxt.wblk = shift_mode_en;
      s_nxt.single = single_chain_select;
      // Thermal flags from synchronised comparators
      s_nxt.hot = temp_s[0];
      s_nxt.shut = temp_s[0] && !overtemp_override;
      s_nxt.warm = temp_s[1];
      ev[IRQ_HOT] = temp_s[0] && !s_r.hot;
      ev[IRQ_WARM] = temp_s[1] && !s_r.warm;
      // Reset interrupts wait for the die to pass the minimum
      s_nxt.take = s_r.pend && (cold_start_wait_bypass || temp_s[2]);
      s_nxt.pend = reset_irq_req || (s_r.pend && !s_nxt.take);
      ev[IRQ_RSTI] = s_nxt.take;
      // Sticky status, an event beats a clear in the same cycle
      s_nxt.status = (s_r.status & ~clr) | ev;
      s_nxt.irq = |(s_nxt.status & s_nxt.mask);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RST;
         s_r.status <= IRQ_RST;
         s_r.mask <= IRQ_RST;
         s_r.pin <= 1'b1;
         s_r.ratio <= RATIO_RST;
         s_r.route <= ROUTE_TCK;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bvalid = s_r.bvalid;
   assign bresp = s_r.bresp;
   assign rvalid = s_r.rvalid;
   assign rdata = s_r.rdata;
   assign rresp = s_r.rresp;
   assign irq = s_r.irq;
   assign bp_strobe = s_r.pin;
   assign ratio_cfg = s_r.ratio;
   assign proc_clk_bypass = s_r.byp;
   assign pll_enable = !s_r.byp;
   assign clk_route = s_r.route;
   assign speed_trig_armed = s_r.armed;
   assign scan_mode = s_r.scan;
   assign ram_we_block = s_r.wblk;
   assign scan_single_chain = s_r.single;
   assign overtemp_flag = s_r.hot;
   assign warm_flag = s_r.warm;
   assign shutdown = s_r.shut;
   assign reset_irq_take = s_r.take;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   localparam int BRK_WIN = 40;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence pulse_start;
      s_r.brk == BRK_WAIT && bus_tick;
   endsequence
   sequence speed_edge;
      spd_edge;
   endsequence
   AST_PULSE_ONE_BUS: assert property (s_r.brk == BRK_PULSE && bus_tick && !bp_trigger
      && !s_r.again |=> s_r.brk == BRK_IDLE)
      else $error("strobe pulse outlived one bus clock");
   AST_PULSE_SOON: assert property (s_r.brk == BRK_IDLE && bp_trigger && s_r.ctrl[CTRL_EN_BIT]
      |-> ##[1:BRK_WIN] s_r.brk == BRK_PULSE)
      else $error("strobe pulse came too late");
   AST_PIN_LEVEL: assert property (pulse_start |=> bp_strobe == s_r.ctrl[CTRL_POL_BIT])
      else $error("strobe pin level wrong in pulse");
   AST_CFG_HOLD: assert property (!hard_reset_in |=> $stable(ratio_cfg) && $stable(proc_clk_bypass))
      else $error("configuration changed outside hard reset");
   AST_CFG_LATCH: assert property (hard_reset_in |=> ratio_cfg == $past(ratio_cfg_in))
      else $error("ratio not taken during hard reset");
   AST_BYPASS: assert property (hard_reset_in && loop_bypass_in |=> !pll_enable && proc_clk_bypass)
      else $error("bypass did not disable the loop");
   AST_ROUTE: assert property (clock_tree_source_select == SEL_SCAN && s_r.burst == 2'h0
      && !spd_edge |=> clk_route == ROUTE_SCAN)
      else $error("scan speed test source not chosen");
   AST_SPEED: assert property (speed_edge |=> clk_route == ROUTE_CORE [*2])
      else $error("speed test burst not two core cycles");
   AST_SCAN: assert property (shift_mode_en |=> scan_mode && ram_we_block)
      else $error("shift mode not applied");
   AST_CHAIN: assert property (single_chain_select != scan_single_chain
      |=> scan_single_chain == $past(single_chain_select))
      else $error("chain select not followed");
   AST_HOT: assert property (hot_raw [*3] ##1 !overtemp_override |-> overtemp_flag ##0
      (shutdown || $past(overtemp_override)))
      else $error("hot die did not flag or shut down");
   AST_WARM: assert property (warm_raw [*3] |=> warm_flag)
      else $error("warm flag missing");
   AST_COLD: assert property (reset_irq_take |-> $past(cold_start_wait_bypass)
      || $past(temp_s[2]))
      else $error("reset interrupt released on a cold die");
   AST_SYNC: assert property (!hot_raw [*3] |=> !overtemp_flag)
      else $error("hot flag not from synchronised level");
endmodule

// ===== testbench/board_model.sv
// Board model that drives the clock configuration pins under hard reset
`timescale 1ns/1ps
module board_model
   import sideband_pkg::*;
#(
   parameter int HOLD = 3
) (
   // Clock
   input wire logic mclk,
   // Configuration pins
   output logic hard_reset_in,
   output logic [RATIO_W-1:0] ratio_cfg_in,
   output logic loop_bypass_in
);
   // ------------------------------------------------------------
   // Idle pin levels
   // ------------------------------------------------------------
   initial begin
      hard_reset_in = 1'b0;
      ratio_cfg_in = 5'h00;
      loop_bypass_in = 1'b0;
   end
   // ------------------------------------------------------------
   // Configuration change wrapped in hard reset
   // ------------------------------------------------------------
   // Pins move only inside the hard reset window, never outside it
   task automatic apply_cfg(input logic [RATIO_W-1:0] r, input logic b);
      @(posedge mclk);
      hard_reset_in <= 1'b1;
      @(posedge mclk);
      ratio_cfg_in <= r;
      loop_bypass_in <= b;
      repeat (HOLD) @(posedge mclk);
      hard_reset_in <= 1'b0;
      @(posedge mclk);
   endtask
endmodule

// ===== testbench/sideband_ctrl_tb.sv
// Self-checking bench for the processor sideband control block
`timescale 1ns/1ps
module sideband_ctrl_tb
   import sideband_pkg::*;
;
   logic mclk, rstn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, irq, bp_trigger, bp_strobe, hard_reset_in, loop_bypass_in;
   logic proc_clk_bypass, pll_enable, speed_trig_armed, heartbeat_out, shift_mode_en;
   logic single_chain_select, scan_mode, ram_we_block, scan_single_chain, hot_raw, warm_raw;
   logic above_min_raw, overtemp_override, cold_start_wait_bypass, reset_irq_req;
   logic overtemp_flag, warm_flag, shutdown, reset_irq_take;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs, ws, clock_tree_source_select;
   logic [RATIO_W-1:0] ratio_cfg_in, ratio_cfg;
   clk_route_t clk_route;
   clk_route_t route_tab [4] = '{ROUTE_TCK, ROUTE_SCAN, ROUTE_CORE, ROUTE_TCK};
   int num_errors, total_checks, k, n;
   // Design and board model
   sideband_ctrl uut (.mclk, .rstn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
      .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
      .rresp, .irq, .bp_trigger, .bp_strobe, .hard_reset_in, .ratio_cfg_in, .loop_bypass_in,
      .clock_tree_source_select, .ratio_cfg, .proc_clk_bypass, .pll_enable, .clk_route,
      .speed_trig_armed, .heartbeat_out, .shift_mode_en, .single_chain_select, .scan_mode,
      .ram_we_block, .scan_single_chain, .hot_raw, .warm_raw, .above_min_raw,
      .overtemp_override, .cold_start_wait_bypass, .reset_irq_req, .overtemp_flag,
      .warm_flag, .shutdown, .reset_irq_take);
   board_model #(.HOLD(3)) brd (.mclk, .hard_reset_in, .ratio_cfg_in, .loop_bypass_in);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Ends the run when a bounded wait ran out
   task automatic guard(input int w);
      if (w >= 50) begin
         chk("wait", 32'h1, 32'h0);
         conclude();
      end
   endtask
   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (k = 0; k < 50 && !(awready && wready); k++) @(posedge mclk);
      guard(k);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b1;
      for (k = 0; k < 50 && !bvalid; k++) @(posedge mclk);
      guard(k);
      ws = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [ADDR_W-1:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      for (k = 0; k < 50 && !arready; k++) @(posedge mclk);
      guard(k);
      arvalid <= 1'b0;
      rready <= 1'b1;
      for (k = 0; k < 50 && !rvalid; k++) @(posedge mclk);
      guard(k);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // ------------------------------------------------------------
   // Clock, reset and test sequence
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, bp_trigger, shift_mode_en} = '0;
      {single_chain_select, hot_raw, warm_raw, above_min_raw, overtemp_override} = '0;
      {cold_start_wait_bypass, reset_irq_req, awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      clock_tree_source_select = SEL_CORE;
      rstn = 1'b0;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      // Reset values and an unmapped read
      axi_rd(OFS_CTRL);
      chk("ctrl", {30'h0, CTRL_RST}, rd);
      axi_rd(OFS_STATUS);
      chk("status", {28'h0, IRQ_RST}, rd);
      axi_rd(5'h10);
      chk("bad resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      chk("bad data", 32'h0, rd);
      axi_wr(5'h10, 32'h0);
      chk("bad wresp", {30'h0, RESP_SLVERR}, {30'h0, ws});
      $display("test regs done");
      // Clock ratio 3, loop bypassed
      brd.apply_cfg(5'h03, 1'b1);
      chk("ratio", 32'h3, 32'(ratio_cfg));
      chk("bypass", 32'h2, {30'h0, proc_clk_bypass, pll_enable});
      axi_rd(OFS_STATE);
      chk("state", 32'h0310, rd & 32'h1F10);
      $display("test config done");
      // Every select code, then a speed test burst
      for (int c = 0; c < 4; c++) begin
         clock_tree_source_select <= 2'(c);
         repeat (4) @(posedge mclk);
         chk("route", 32'(route_tab[c]), 32'(clk_route));
         chk("armed", 32'(c == 0), 32'(speed_trig_armed));
      end
      clock_tree_source_select <= SEL_SPEED_ARM;
      repeat (4) @(posedge mclk);
      clock_tree_source_select <= SEL_TCK;
      n = 0;
      repeat (8) begin
         @(posedge mclk);
         n += (clk_route === ROUTE_CORE);
      end
      chk("burst", 32'(SPD_BURST), 32'(n));
      chk("after burst", 32'(ROUTE_TCK), 32'(clk_route));
      $display("test clock tree done");
      // Breakpoint pulse at both polarities, with interrupt
      for (int p = 1; p >= 0; p--) begin
         axi_wr(OFS_CTRL, {30'h0, 1'(p), 1'b1});
         chk("idle", 32'(!p), 32'(bp_strobe));
         bp_trigger <= 1'b1;
         @(posedge mclk);
         bp_trigger <= 1'b0;
         for (n = 0; n < 50 && bp_strobe !== 1'(p); n++) @(posedge mclk);
         chk("start", 32'h1, 32'(n <= 6));
         for (n = 0; n < 50 && bp_strobe === 1'(p); n++) @(posedge mclk);
         chk("width", 32'h4, 32'(n));
      end
      axi_wr(OFS_MASK, 32'h1);
      chk("wresp", {30'h0, RESP_OKAY}, {30'h0, ws});
      @(posedge mclk);
      chk("irq", 32'h1, 32'(irq));
      axi_wr(OFS_STATUS, 32'h1);
      @(posedge mclk);
      chk("irq clear", 32'h0, 32'(irq));
      $display("test breakpoint done");
      // Heartbeat high and low runs
      for (n = 0; n < 50 && heartbeat_out !== 1'b0; n++) @(posedge mclk);
      for (n = 0; n < 50 && heartbeat_out === 1'b0; n++) @(posedge mclk);
      for (n = 0; n < 50 && heartbeat_out === 1'b1; n++) @(posedge mclk);
      chk("hb high", 32'h4, 32'(n));
      for (n = 0; n < 50 && heartbeat_out === 1'b0; n++) @(posedge mclk);
      chk("hb low", 32'h4, 32'(n));
      $display("test heartbeat done");
      // Scan controls on and off
      for (int v = 1; v >= 0; v--) begin
         shift_mode_en <= 1'(v);
         single_chain_select <= 1'(v);
         repeat (2) @(posedge mclk);
         chk("scan", {3{1'(v)}}, {scan_mode, ram_we_block, scan_single_chain});
      end
      $display("test scan done");
      // Hot and warm, shutdown and its override
      hot_raw <= 1'b1;
      warm_raw <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("hot", 32'h7, {overtemp_flag, warm_flag, shutdown});
      overtemp_override <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("override", 32'h6, {overtemp_flag, warm_flag, shutdown});
      hot_raw <= 1'b0;
      warm_raw <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("cool", 32'h0, {overtemp_flag, warm_flag, shutdown});
      $display("test thermal done");
      // Reset interrupt held while cold, then bypassed
      for (int b = 0; b < 2; b++) begin
         cold_start_wait_bypass <= 1'(b);
         reset_irq_req <= 1'b1;
         @(posedge mclk);
         reset_irq_req <= 1'b0;
         for (n = 0; n < 8 && reset_irq_take !== 1'b1; n++) @(posedge mclk);
         chk("cold take", 32'(b), 32'(n < 8));
         above_min_raw <= 1'b1;
         for (n = 0; n < 50 && b == 0 && reset_irq_take !== 1'b1; n++) @(posedge mclk);
         guard(n);
         above_min_raw <= 1'b0;
         repeat (4) @(posedge mclk);
      end
      $display("test reset irq done");
      conclude();
   end
endmodule
